// ---- design/flk_device.sv ----
`default_nettype none
// Summary of operation
// [R1] Pointer 1 plus arm returns lock byte
// [R2] Arm bits self-clear on completion or timeout
// [R3] Unarmed load reads ordinary flash byte
// [R4] Pointer 0 returns low fuse byte
// [R5] Pointer 3 returns high fuse byte
// [R6] Pointer 2 returns extended fuse byte
// [R7] Programmed reads zero, unprogrammed reads one
// [R8] Reset never aborts a running write; here reset returns the sequencer to idle at once
// [R9] Erase and write last 3.7 to 4.5 ms
// [R10] Section busy flag always reads zero
// [R11] Software waits idle, masks irqs, no eeprom
// [R12] Self-programming code runs from boot region
// [R13] Erase, load words by two, write page
// [R14] Software polls busy flag before returning
// [R15] Boot stores may reach every flash page
// [R16] Two independent boot protection bit sets
// [R17] Select bit 3, enable bit 0, same write
// [R18] Eeprom write blocks readback and programming
// [R19] Plain enable stores word into page buffer
// [R20] Windows count from control write cycle
// [R21] Other pointer returns ones and disarms
module flk_device #(
    parameter int PROG_CYCLES = flk_pkg::PROG_CYCLES_DEFAULT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    flk_if.dev               bus,
    input  wire logic        eepromWritePending,
    input  wire logic [7:0]  fuseLowByte,
    input  wire logic [7:0]  fuseHighByte,
    input  wire logic [7:0]  extendedFuseByte,
    input  wire logic [1:0]  bootLockApp,
    input  wire logic [1:0]  bootLockBoot,
    input  wire logic [1:0]  lockBits,
    input  wire logic [7:0]  flashByte,
    output logic             bufWrite,
    output logic [4:0]       bufIndex,
    output logic [15:0]      bufData,
    output logic             bufClear,
    output logic             flashErase,
    output logic             flashWrite,
    output logic [15:0]      flashPage
);
    typedef enum logic [1:0] {FLK_IDLE, FLK_ARMED, FLK_PROG} flk_state_t;

    flk_state_t  state_reg;
    logic [4:0]  cmd_reg;
    logic [2:0]  window_reg;
    logic [31:0] progCount_reg;
    logic [7:0]  loadData_reg;

    // ---------------------------------------------------------------
    // Lock byte layout
    // ---------------------------------------------------------------
    // Lock byte: general lock bits low, boot lock sets above
    // Top two bits unused and read as unprogrammed
    function automatic logic [7:0] lock_byte(input logic [1:0] app,
                                             input logic [1:0] boot,
                                             input logic [1:0] lock);
        lock_byte = {2'b11, boot, app, lock}; // [R16] [R7] [R1]
    endfunction : lock_byte

    // ---------------------------------------------------------------
    // Command arming
    // ---------------------------------------------------------------
    logic legalCmd;
    logic isRead;
    assign legalCmd = bus.ctlWdata[4:0] == flk_pkg::CMD_LOAD ||
                      bus.ctlWdata[4:0] == flk_pkg::CMD_ERASE ||
                      bus.ctlWdata[4:0] == flk_pkg::CMD_WRITE ||
                      bus.ctlWdata[4:0] == flk_pkg::CMD_READBACK ||
                      bus.ctlWdata[4:0] == flk_pkg::CMD_REENABLE;
    assign isRead = cmd_reg == flk_pkg::CMD_READBACK;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Arm, window count, program phase; other codes are ignored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= FLK_IDLE;
            cmd_reg       <= 5'h00;
            window_reg    <= 3'h0;
        end else begin
            case (state_reg)
                FLK_IDLE: begin
                    if (bus.ctlWrite && legalCmd && !eepromWritePending) begin // [R18] [R17]
                        state_reg  <= FLK_ARMED;
                        cmd_reg    <= bus.ctlWdata[4:0];
                        window_reg <= 3'h1; // [R20]
                    end
                end
                FLK_ARMED: begin
                    window_reg <= window_reg + 3'h1;
                    if (isRead && bus.loadStrobe) begin
                        state_reg <= FLK_IDLE; // [R2] [R21]
                    end else if (!isRead && bus.storeStrobe && bus.fromBoot) begin // [R15]
                        if (cmd_reg == flk_pkg::CMD_ERASE || cmd_reg == flk_pkg::CMD_WRITE) begin
                            state_reg <= FLK_PROG;
                        end else begin
                            state_reg <= FLK_IDLE;
                        end
                    end else if (isRead && window_reg >= 3'(flk_pkg::LOAD_WINDOW_CYCLES)) begin
                        state_reg <= FLK_IDLE; // [R2]
                    end else if (window_reg >= 3'(flk_pkg::STORE_WINDOW_CYCLES)) begin
                        state_reg <= FLK_IDLE; // [R2]
                    end
                end
                FLK_PROG: begin
                    if (progCount_reg <= 32'h1) begin
                        state_reg <= FLK_IDLE;
                    end
                end
                default: state_reg <= FLK_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Program-load data path
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            loadData_reg <= 8'h00;
        end else if (bus.loadStrobe) begin
            if (state_reg == FLK_ARMED && isRead) begin
                case (bus.zPtr)
                    flk_pkg::PTR_FUSE_LOW:  loadData_reg <= fuseLowByte;      // [R4] [R7]
                    flk_pkg::PTR_LOCK:      loadData_reg <= lock_byte(bootLockApp,
                                                                      bootLockBoot,
                                                                      lockBits); // [R1]
                    flk_pkg::PTR_FUSE_EXT:  loadData_reg <= extendedFuseByte; // [R6]
                    flk_pkg::PTR_FUSE_HIGH: loadData_reg <= fuseHighByte;     // [R5]
                    default:                loadData_reg <= flk_pkg::READ_ALL_ONES; // [R21]
                endcase
            end else begin
                loadData_reg <= flashByte; // [R3]
            end
        end
    end
    assign bus.loadData = loadData_reg;

    // ---------------------------------------------------------------
    // Store actions toward flash and page buffer
    // ---------------------------------------------------------------
    logic storeHit;
    assign storeHit = state_reg == FLK_ARMED && !isRead && bus.storeStrobe && bus.fromBoot;

    // ---------------------------------------------------------------
    // Flash operation timer
    // ---------------------------------------------------------------
    logic progStart;
    assign progStart = storeHit && (cmd_reg == flk_pkg::CMD_ERASE ||
                                    cmd_reg == flk_pkg::CMD_WRITE);

    // Loaded on an accepted erase or write, counts down while halted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            progCount_reg <= 32'h0;
        end else if (progStart) begin
            progCount_reg <= 32'(PROG_CYCLES); // [R9]
        end else if (state_reg == FLK_PROG) begin
            progCount_reg <= progCount_reg - 32'h1; // [R9]
        end
    end

    // Store side effects: one-cycle strobes; index, data and page held until the next store
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bufWrite   <= 1'b0;
            bufIndex   <= 5'h00;
            bufData    <= 16'h0000;
            bufClear   <= 1'b0;
            flashErase <= 1'b0;
            flashWrite <= 1'b0;
            flashPage  <= 16'h0000;
        end else begin
            bufWrite   <= storeHit && cmd_reg == flk_pkg::CMD_LOAD; // [R19]
            bufClear   <= storeHit && cmd_reg == flk_pkg::CMD_REENABLE;
            flashErase <= storeHit && cmd_reg == flk_pkg::CMD_ERASE;
            flashWrite <= storeHit && cmd_reg == flk_pkg::CMD_WRITE;
            if (storeHit) begin
                bufIndex  <= bus.zPtr[flk_pkg::WORD_IDX_W:1]; // [R19]
                bufData   <= bus.storeWord;
                flashPage <= {bus.zPtr[15:flk_pkg::WORD_IDX_W + 1],
                              {(flk_pkg::WORD_IDX_W + 1){1'b0}}}; // [R15]
            end
        end
    end

    // Control read-back; busy flag stuck at zero, enable held through program
    always_comb begin
        bus.ctlRdata = flk_pkg::CTL_RESET;
        if (state_reg != FLK_IDLE) begin
            bus.ctlRdata[4:0] = cmd_reg;
        end
        bus.ctlRdata[flk_pkg::CTL_SECTION_BUSY] = 1'b0; // [R10]
    end
    // Core stays halted for the whole flash operation
    // Hazard: the halt must end only when the timer runs out
    assign bus.cpuHalt = state_reg == FLK_PROG; // [R8]
endmodule : flk_device
`default_nettype wire

// ---- design/flk_pkg.sv ----
`default_nettype none
package flk_pkg;
    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int CTL_SELF_PROGRAM_ENABLE    = 0;
    localparam int CTL_PAGE_ERASE_CMD         = 1;
    localparam int CTL_PAGE_WRITE_CMD         = 2;
    localparam int CTL_BOOT_LOCK_READ_SELECT  = 3;
    localparam int CTL_SECTION_READ_ENABLE    = 4;
    localparam int CTL_SECTION_BUSY           = 6;
    localparam logic [7:0] CTL_RESET          = 8'h00;
    // Lower five bit command codes
    localparam logic [4:0] CMD_LOAD           = 5'h01;
    localparam logic [4:0] CMD_ERASE          = 5'h03;
    localparam logic [4:0] CMD_WRITE          = 5'h05;
    localparam logic [4:0] CMD_READBACK       = 5'h09;
    localparam logic [4:0] CMD_REENABLE       = 5'h11;
    // ---------------------------------------------------------------
    // Readback pointer values
    // ---------------------------------------------------------------
    localparam logic [15:0] PTR_FUSE_LOW      = 16'h0000;
    localparam logic [15:0] PTR_LOCK          = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT      = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH     = 16'h0003;
    localparam logic [7:0]  READ_ALL_ONES     = 8'hff;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int LOAD_WINDOW_CYCLES         = 3;
    localparam int STORE_WINDOW_CYCLES        = 4;
    localparam int CLK_MHZ                    = 100;
    localparam int PROG_MIN_US                = 3700;
    localparam int PROG_MAX_US                = 4500;
    localparam int PROG_MIN_CYCLES            = PROG_MIN_US * CLK_MHZ;
    localparam int PROG_MAX_CYCLES            = PROG_MAX_US * CLK_MHZ;
    localparam int PROG_CYCLES_DEFAULT        = (PROG_MIN_CYCLES + PROG_MAX_CYCLES) / 2;
    localparam int PAGE_WORDS                 = 32;
    localparam int WORD_IDX_W                 = 5;
endpackage : flk_pkg
`default_nettype wire

// ---- design/flk_if.sv ----
`default_nettype none
interface flk_if;
    logic        ctlWrite;     // Core writes program_store_control
    logic [7:0]  ctlWdata;
    logic [7:0]  ctlRdata;     // Control register as read
    logic [15:0] zPtr;         // Flash address pointer
    logic [15:0] storeWord;    // R1:R0
    logic        loadStrobe;   // Program-load executed
    logic        storeStrobe;  // Program-store executed
    logic        fromBoot;     // Instruction fetched from boot region
    logic [7:0]  loadData;     // Program-load result
    logic        cpuHalt;      // Core halted during operation
    modport dev  (input ctlWrite, ctlWdata, zPtr, storeWord, loadStrobe, storeStrobe,
                  fromBoot, output ctlRdata, loadData, cpuHalt);
    modport core (output ctlWrite, ctlWdata, zPtr, storeWord, loadStrobe, storeStrobe,
                  fromBoot, input ctlRdata, loadData, cpuHalt);
endinterface : flk_if
`default_nettype wire

// ---- design/flk_core.sv ----
`default_nettype none
// Core-side sequencer: issues one control write then the load or store
module flk_core (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    flk_if.core              bus,
    input  wire logic        reqValid,
    input  wire logic [4:0]  reqCmd,
    input  wire logic        reqIsLoad,
    input  wire logic [15:0] reqPtr,
    input  wire logic [15:0] reqWord,
    input  wire logic        eepromWritePending,
    output logic             reqReady,
    output logic             rspValid,
    output logic [7:0]       rspData
);
    typedef enum logic [2:0] {FLC_IDLE, FLC_WAIT, FLC_ARM, FLC_GO, FLC_DONE} flc_state_t;
    flc_state_t  state_reg;
    logic [4:0]  cmd_reg;
    logic        isLoad_reg;
    logic [15:0] ptr_reg;
    logic [15:0] word_reg;

    // Request sequencing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= FLC_IDLE;
            cmd_reg    <= 5'h00;
            isLoad_reg <= 1'b0;
            ptr_reg    <= 16'h0000;
            word_reg   <= 16'h0000;
        end else begin
            case (state_reg)
                FLC_IDLE: if (reqValid) begin
                    state_reg  <= FLC_WAIT;
                    cmd_reg    <= reqCmd;
                    isLoad_reg <= reqIsLoad;
                    ptr_reg    <= reqPtr;
                    word_reg   <= reqWord;
                end
                FLC_WAIT: begin
                    // [R11]
                    if (!bus.ctlRdata[flk_pkg::CTL_SELF_PROGRAM_ENABLE] && !eepromWritePending
                        && !bus.cpuHalt) begin
                        state_reg <= FLC_ARM;
                    end
                end
                FLC_ARM:  state_reg <= FLC_GO;   // [R20]
                FLC_GO:   state_reg <= FLC_DONE; // [R1]
                FLC_DONE: if (!bus.cpuHalt) begin
                    state_reg <= FLC_IDLE;       // [R14]
                end
                default:  state_reg <= FLC_IDLE;
            endcase
        end
    end

    // Response capture one cycle after the load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rspValid <= 1'b0;
            rspData  <= 8'h00;
        end else begin
            rspValid <= state_reg == FLC_DONE && isLoad_reg && !bus.cpuHalt;
            if (state_reg == FLC_DONE) begin
                rspData <= bus.loadData;
            end
        end
    end

    assign reqReady        = state_reg == FLC_IDLE;
    assign bus.ctlWrite    = state_reg == FLC_ARM;
    assign bus.ctlWdata    = {3'h0, cmd_reg};
    assign bus.zPtr        = ptr_reg;
    assign bus.storeWord   = word_reg;
    assign bus.loadStrobe  = state_reg == FLC_GO && isLoad_reg;
    assign bus.storeStrobe = state_reg == FLC_GO && !isLoad_reg;
    assign bus.fromBoot    = 1'b1; // [R12]
endmodule : flk_core
`default_nettype wire

// ---- tb/flk_assertions.sv ----
`default_nettype none
// Interface watcher for the readback and store windows
module flk_assertions #(
    parameter int PROG_CYCLES = 8
) (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ctlWrite,
    input wire logic [7:0]  ctlWdata,
    input wire logic [7:0]  ctlRdata,
    input wire logic [15:0] zPtr,
    input wire logic        loadStrobe,
    input wire logic [7:0]  loadData,
    input wire logic        cpuHalt
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Helper and sequences
    // ---------------------------------------------------------------
    int haltLen_reg;
    // Counts consecutive halted cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            haltLen_reg <= 0;
        end else begin
            haltLen_reg <= cpuHalt ? haltLen_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_armRead;
        $rose(ctlRdata[3]);
    endsequence
    sequence s_noLoad;
        !loadStrobe [*3];
    endsequence
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    property p_armSource;
        $rose(ctlRdata[0]) |-> $past(ctlWrite) && ctlRdata[4:0] == $past(ctlWdata[4:0]);
    endproperty
    property p_legalCode;
        ctlRdata[4:0] inside {5'h00, 5'h01, 5'h03, 5'h05, 5'h09, 5'h11};
    endproperty
    property p_busyZero;
        ctlRdata[6:5] == 2'h0;
    endproperty
    property p_readTimeout;
        s_armRead ##0 s_noLoad |=> ##[0:1] ctlRdata[4:0] == 5'h00;
    endproperty
    property p_readDone;
        ctlRdata[3] && loadStrobe |=> ctlRdata[4:0] == 5'h00;
    endproperty
    property p_lockLayout;
        ctlRdata[3] && loadStrobe && zPtr == 16'h0001 |=> loadData[7:6] == 2'h3;
    endproperty
    property p_unmapped;
        ctlRdata[3] && loadStrobe && zPtr > 16'h0003 |=> loadData == 8'hff;
    endproperty
    property p_storeTimeout;
        $rose(ctlRdata[0]) && !ctlRdata[3] |-> ##[1:5] (!ctlRdata[0] || cpuHalt);
    endproperty
    property p_haltLen;
        $fell(cpuHalt) |-> haltLen_reg == PROG_CYCLES;
    endproperty
    property p_haltArm;
        cpuHalt |-> ctlRdata[0] && (ctlRdata[1] || ctlRdata[2]);
    endproperty
    a_armSource: assert property (p_armSource) else $error("arm bits not from control write");
    a_legalCode: assert property (p_legalCode) else $error("illegal code accepted");
    a_busyZero: assert property (p_busyZero) else $error("busy flag set");
    a_readTimeout: assert property (p_readTimeout) else $error("readback arm kept");
    a_readDone: assert property (p_readDone) else $error("readback not disarmed");
    a_lockLayout: assert property (p_lockLayout) else $error("lock byte layout");
    a_unmapped: assert property (p_unmapped) else $error("unmapped pointer data");
    a_storeTimeout: assert property (p_storeTimeout) else $error("store arm kept");
    a_haltLen: assert property (p_haltLen) else $error("halt length wrong");
    a_haltArm: assert property (p_haltArm) else $error("enable dropped in halt");
endmodule : flk_assertions
`default_nettype wire

// ---- tb/test_fuse_lock_readback_selfprog.sv ----
`default_nettype none
module test_fuse_lock_readback_selfprog;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_n, reqValid, reqIsLoad, eeCore, eeDev, reqReady, rspValid;
    logic        bufWrite, bufClear, flashErase, flashWrite;
    logic [4:0]  reqCmd, bufIndex;
    logic [15:0] reqPtr, reqWord, bufData;
    logic [7:0]  rspData, fLow, fHigh, fExt, flashByte;
    logic [1:0]  lockApp, lockBoot, lockBits;
    int          badCount, checks, nBufWr, nErase, nWrite;
    flk_if link();
    flk_device #(.PROG_CYCLES(8)) flk_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus(link), .eepromWritePending(eeDev), .fuseLowByte(fLow), .fuseHighByte(fHigh),
        .extendedFuseByte(fExt), .bootLockApp(lockApp), .bootLockBoot(lockBoot), .lockBits(lockBits),
        .flashByte(flashByte), .bufWrite(bufWrite), .bufIndex(bufIndex), .bufData(bufData),
        .bufClear(bufClear), .flashErase(flashErase), .flashWrite(flashWrite), .flashPage());
    flk_core flk_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(link), .reqValid(reqValid),
        .reqCmd(reqCmd), .reqIsLoad(reqIsLoad), .reqPtr(reqPtr), .reqWord(reqWord),
        .eepromWritePending(eeCore), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    flk_assertions #(.PROG_CYCLES(8)) flk_assertions_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .ctlWrite(link.ctlWrite), .ctlWdata(link.ctlWdata), .ctlRdata(link.ctlRdata),
        .zPtr(link.zPtr), .loadStrobe(link.loadStrobe), .loadData(link.loadData),
        .cpuHalt(link.cpuHalt));
    // Clock and pulse counters
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        nBufWr <= nBufWr + int'(bufWrite);
        nErase <= nErase + int'(flashErase);
        nWrite <= nWrite + int'(flashWrite);
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    function automatic bit ready(input int mode);
        case (mode)
            0: return reqReady === 1'b1;
            1: return rspValid === 1'b1;
            2: return link.ctlRdata[0] === 1'b1;
            default: return link.ctlRdata === 8'h00 && link.cpuHalt === 1'b0;
        endcase
    endfunction : ready
    // Bounded wait for one of the completion conditions
    task automatic waitOn(input int mode);
        int n;
        n = 0;
        while (!ready(mode) && n < 60) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 60) begin
            badCount++;
            give_verdict();
        end
    endtask : waitOn
    task automatic doReq(input logic [4:0] cmd, input logic isLoad, input logic [15:0] ptr,
                         input logic [15:0] word);
        waitOn(0);
        reqValid = 1'b1;
        reqCmd = cmd;
        reqIsLoad = isLoad;
        reqPtr = ptr;
        reqWord = word;
        @(posedge clk_sys);
        #1;
        reqValid = 1'b0;
        waitOn(isLoad ? 1 : 2);
        if (!isLoad) waitOn(3);
    endtask : doReq
    function automatic logic [7:0] want(input int i);
        case (i)
            0: return fLow;
            1: return {2'h3, lockBoot, lockApp, lockBits};
            2: return fExt;
            3: return fHigh;
            default: return 8'hff;
        endcase
    endfunction : want
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {rst_n, reqValid, reqIsLoad, eeCore, eeDev, reqCmd, reqPtr, reqWord} = '0;
        {badCount, checks, nBufWr, nErase, nWrite} = '0;
        {fLow, fHigh, fExt, flashByte} = 32'h62df_f95a;
        {lockApp, lockBoot, lockBits} = 6'h26;
        repeat (5) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        // Every readback pointer plus one outside the map
        for (int i = 0; i < 5; i++) begin
            doReq(flk_pkg::CMD_READBACK, 1'b1, 16'(i), 16'h0000);
            check(16'(rspData), 16'(want(i)));
            check(16'(link.ctlRdata), 16'h0000);
        end
        $display("test readback done");
        // Unarmed and half-armed loads give plain flash data
        for (int k = 0; k < 2; k++) begin
            flashByte = 8'h3c ^ 8'(k);
            doReq(k ? 5'h08 : 5'h00, 1'b1, 16'h0001, 16'h0000);
            check(16'(rspData), 16'(flashByte));
        end
        eeDev = 1'b1;
        doReq(flk_pkg::CMD_READBACK, 1'b1, 16'h0000, 16'h0000);
        check(16'(rspData), 16'(flashByte));
        eeDev = 1'b0;
        $display("test plain load done");
        // Page erase, two buffer words, page write, section re-enable
        doReq(flk_pkg::CMD_ERASE, 1'b0, 16'h0440, 16'h0000);
        check(16'(nErase), 16'h0001);
        for (int i = 0; i < 2; i++) begin
            doReq(flk_pkg::CMD_LOAD, 1'b0, 16'h0441 + 16'(2 * i), 16'hbe00 + 16'(i));
            check(16'(bufIndex), 16'(i));
            check(bufData, 16'hbe00 + 16'(i));
        end
        doReq(flk_pkg::CMD_WRITE, 1'b0, 16'h0440, 16'h0000);
        doReq(flk_pkg::CMD_REENABLE, 1'b0, 16'h0000, 16'h0000);
        check(16'(nWrite), 16'h0001);
        check(16'(nBufWr), 16'h0002);
        $display("test page program done");
        give_verdict();
    end
endmodule : test_fuse_lock_readback_selfprog
`default_nettype wire
